// [pkg/ccp_pkg.sv]
package ccp_pkg;

    // AXI4-Lite register map (byte addresses)
    localparam logic [7:0] CCP_CTRL_OFS = 8'h00;
    localparam logic [7:0] CCP_STAT_OFS = 8'h04;
    localparam logic [7:0] CCP_IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] CCP_IRQ_MASK_OFS = 8'h0c;

    // Control register fields
    localparam int CCP_CTRL_SEL_LV_N = 0;
    localparam int CCP_CTRL_SEL_HV = 1;
    localparam int CCP_CTRL_RST_REQ = 2;
    localparam int CCP_CTRL_SESS_N = 3;
    localparam int CCP_CTRL_DIV_A = 4;
    localparam int CCP_CTRL_DIV_B = 5;
    localparam int CCP_CTRL_SUPPLY_OK = 6;
    localparam logic [31:0] CCP_CTRL_RESET = 32'h0000_000b;

    // Interrupt status bits
    localparam int CCP_IRQ_PRES_CHG = 0;
    localparam int CCP_IRQ_SUPPLY_FAIL = 1;
    localparam int CCP_IRQ_ACT_START = 2;
    localparam int CCP_IRQ_W = 3;

    // Debounce time and derived cycles at 40 MHz
    localparam int CCP_CLK_HZ = 40_000_000;
    localparam int CCP_DEBOUNCE_US = 8000;
    localparam int CCP_DEBOUNCE_CYC = CCP_CLK_HZ / 1_000_000 * CCP_DEBOUNCE_US;

    typedef enum logic [1:0] {
        CCP_SUP_3V0 = 2'b00,
        CCP_SUP_5V0 = 2'b01,
        CCP_SUP_1V8 = 2'b10,
        CCP_SUP_OFF = 2'b11
    } ccp_supply_t;

    typedef enum logic [1:0] {
        CCP_ST_SHUTDOWN = 2'b00,
        CCP_ST_ACTIVE = 2'b01,
        CCP_ST_DEEP = 2'b10
    } ccp_state_t;

    localparam logic [1:0] CCP_BRESP_OK = 2'b00;
    localparam logic [1:0] CCP_BRESP_DECERR = 2'b11;

endpackage

// [core/ccp_ctrl.sv]
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// R1: With the 1.8 V select high, the high select picks a 5 V card supply when high, 3 V when low.
// R2: A low 1.8 V select requests 1.8 V; high disables the 1.8 V choice.
// R3: The card reset request passes to the card reset contact without inversion.
// R4: A low session command requests the start of activation.
// R5: The card clock rate comes from the two divider select levels together.
// R6: Select a,b of 00 gives 1/8, 01 gives 1/4, 11 gives 1/2, 10 gives the full clock.
// R7: A low presence input means card present, acted on after an 8 ms debounce.
// R8: Status and faults are signalled on an active-low open-drain interrupt output.
// R9: After power-up the interrupt stays low until session is high and a card is present.
// R10: On power-down the interrupt goes low as soon as the regulator supply falls too low; in deep mode it drops one cycle later, after leaving deep.
// R11: Every card contact stays inactive during power-up and power-down.
// R12: The internal oscillator stays in low-frequency mode while the session command is high.
// R13: Session high with both selectors low enters deep power-saving; any change wakes it.
// R14: Voltage selectors are sampled at activation start and held for the session.
module ccp_ctrl #(
    parameter int DEBOUNCE_CYC = ccp_pkg::CCP_DEBOUNCE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic card_present_n,
    input wire logic card_clock_in,
    output logic card_clock,
    output logic card_reset,
    output logic [1:0] card_supply_sel,
    output logic card_contacts_active,
    output logic osc_high_freq,
    output logic deep_power_save,
    output logic status_interrupt_out,
    output logic status_interrupt_oe_n,
    output logic irq
);
    import ccp_pkg::*;

    localparam int DBW = $clog2(DEBOUNCE_CYC + 1);

    function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Bus-side registers
    logic [31:0] ctrl_ff;
    logic [CCP_IRQ_W-1:0] istat_ff, imask_ff;
    logic aw_ff, w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;

    // Pin synchronisers
    logic pres_s1_ff, pres_s2_ff, cki_s1_ff, cki_s2_ff, cki_d_ff;
    logic pres_db_ff;
    logic [DBW-1:0] db_cnt_ff;
    logic powered_ff;
    logic [1:0] sup_ff;
    ccp_state_t state_ff;
    logic [2:0] div_ff;
    logic clk_ff, rst_ff, act_ff, osc_ff, deep_ff, int_n_ff, irq_ff;
    logic [2:0] wake_ref_ff;

    wire sel_lv_n = ctrl_ff[CCP_CTRL_SEL_LV_N];
    wire sel_hv = ctrl_ff[CCP_CTRL_SEL_HV];
    wire sess_n = ctrl_ff[CCP_CTRL_SESS_N];
    wire supply_ok = ctrl_ff[CCP_CTRL_SUPPLY_OK];
    wire [2:0] wake_now = {sess_n, sel_lv_n, sel_hv};

    wire wr_fire = aw_ff && w_ff && !bvalid_ff;
    wire wr_ctrl = wr_fire && awaddr_ff == CCP_CTRL_OFS;
    wire wr_istat = wr_fire && awaddr_ff == CCP_IRQ_STAT_OFS;
    wire wr_imask = wr_fire && awaddr_ff == CCP_IRQ_MASK_OFS;
    wire wr_hit = wr_ctrl || wr_istat || wr_imask || (wr_fire && awaddr_ff == CCP_STAT_OFS);
    wire rd_fire = s_axi_arvalid && arready_ff;

    wire pres_raw = !pres_s2_ff;
    wire db_done = db_cnt_ff == DBW'(DEBOUNCE_CYC - 1);
    wire pres_chg = pres_raw != pres_db_ff && db_done;
    wire card_in = pres_db_ff;

    // Supply choice: 1.8 V select dominates the 5/3 V select
    wire [1:0] sup_req = !sel_lv_n ? CCP_SUP_1V8 : (sel_hv ? CCP_SUP_5V0 : CCP_SUP_3V0); // R1 R2
    wire act_req = !sess_n && card_in && supply_ok && state_ff != CCP_ST_ACTIVE; // R4
    wire sess_end = state_ff == CCP_ST_ACTIVE && (sess_n || !card_in || !supply_ok);
    wire deep_cond = sess_n && !sel_lv_n && !sel_hv && supply_ok; // R13
    wire div_sel_a = ctrl_ff[CCP_CTRL_DIV_A];
    wire div_sel_b = ctrl_ff[CCP_CTRL_DIV_B];
    // Counts both input edges so full rate needs no second clock
    wire [2:0] div_tick = {div_sel_a, div_sel_b} == 2'b00 ? 3'h7 :
                          {div_sel_a, div_sel_b} == 2'b01 ? 3'h3 :
                          {div_sel_a, div_sel_b} == 2'b11 ? 3'h1 : 3'h0; // R5 R6
    wire cki_edge = cki_s2_ff != cki_d_ff;
    wire div_wrap = (div_ff & div_tick) == div_tick;
    wire [CCP_IRQ_W-1:0] ev = {act_req, !supply_ok && powered_ff, pres_chg};
    wire [31:0] status_word = {22'h0, int_n_ff, deep_ff, osc_ff, act_ff,
                               2'(state_ff), sup_ff, card_in, powered_ff};
    wire [31:0] rd_word = s_axi_araddr == CCP_CTRL_OFS ? ctrl_ff :
                          s_axi_araddr == CCP_STAT_OFS ? status_word :
                          s_axi_araddr == CCP_IRQ_STAT_OFS ? {29'h0, istat_ff} :
                          s_axi_araddr == CCP_IRQ_MASK_OFS ? {29'h0, imask_ff} : 32'h0;
    wire rd_hit = s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= CCP_BRESP_OK;
        end else begin
            if (s_axi_awvalid && !aw_ff) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_ff) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_hit ? CCP_BRESP_OK : CCP_BRESP_DECERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= CCP_BRESP_OK;
        end else begin
            arready_ff <= !rvalid_ff && !arready_ff && s_axi_arvalid;
            if (rd_fire) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_hit ? rd_word : 32'h0000_0000;
                rresp_ff <= rd_hit ? CCP_BRESP_OK : CCP_BRESP_DECERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= CCP_CTRL_RESET;
            istat_ff <= '0;
            imask_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= wr_merge(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_007f;
            end
            if (wr_imask) begin
                imask_ff <= wdata_ff[CCP_IRQ_W-1:0];
            end
            istat_ff <= (istat_ff & ~(wr_istat ? wdata_ff[CCP_IRQ_W-1:0] : '0)) | ev;
            irq_ff <= |(istat_ff & imask_ff);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pres_s1_ff <= 1'b1;
            pres_s2_ff <= 1'b1;
            cki_s1_ff <= 1'b0;
            cki_s2_ff <= 1'b0;
            cki_d_ff <= 1'b0;
        end else begin
            pres_s1_ff <= card_present_n;
            pres_s2_ff <= pres_s1_ff;
            cki_s1_ff <= card_clock_in;
            cki_s2_ff <= cki_s1_ff;
            cki_d_ff <= cki_s2_ff;
        end
    end

    // Debounce restarts on every bounce of the contact
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            db_cnt_ff <= '0;
            pres_db_ff <= 1'b0;
        end else if (pres_raw == pres_db_ff) begin
            db_cnt_ff <= '0;
        end else if (db_done) begin
            db_cnt_ff <= '0;
            pres_db_ff <= pres_raw; // R7
        end else begin
            db_cnt_ff <= db_cnt_ff + DBW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= CCP_ST_SHUTDOWN;
            sup_ff <= CCP_SUP_OFF;
            powered_ff <= 1'b0;
            wake_ref_ff <= 3'h0;
        end else begin
            powered_ff <= supply_ok;
            unique case (state_ff)
                CCP_ST_SHUTDOWN: begin
                    if (act_req) begin
                        state_ff <= CCP_ST_ACTIVE;
                        sup_ff <= sup_req; // R14
                    end else if (deep_cond) begin
                        state_ff <= CCP_ST_DEEP;
                        wake_ref_ff <= wake_now;
                    end
                end
                CCP_ST_ACTIVE: begin
                    if (sess_end) begin
                        state_ff <= CCP_ST_SHUTDOWN;
                        sup_ff <= CCP_SUP_OFF;
                    end
                end
                CCP_ST_DEEP: begin
                    if (wake_now != wake_ref_ff || !supply_ok) begin
                        state_ff <= CCP_ST_SHUTDOWN; // R13
                    end
                end
                default: state_ff <= CCP_ST_SHUTDOWN;
            endcase
        end
    end

    // Contacts only live in an active session with good supply
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_ff <= 3'h0;
            clk_ff <= 1'b0;
            rst_ff <= 1'b0;
            act_ff <= 1'b0;
            osc_ff <= 1'b0;
            deep_ff <= 1'b0;
            int_n_ff <= 1'b0;
        end else begin
            act_ff <= state_ff == CCP_ST_ACTIVE && !sess_end; // R11
            osc_ff <= !sess_n && state_ff == CCP_ST_ACTIVE; // R12
            deep_ff <= state_ff == CCP_ST_DEEP;
            rst_ff <= act_ff && ctrl_ff[CCP_CTRL_RST_REQ]; // R3
            if (cki_edge) begin
                div_ff <= div_ff + 3'h1;
                if (div_wrap) begin
                    div_ff <= 3'h0;
                    clk_ff <= act_ff ? !clk_ff : 1'b0; // R5
                end
            end
            if (!act_ff) begin
                clk_ff <= 1'b0;
            end
            // Deep mode: interrupt follows presence only
            int_n_ff <= state_ff == CCP_ST_DEEP ? card_in :
                        supply_ok && powered_ff && card_in && (sess_n || act_ff); // R8 R9 R10
        end
    end

    assign s_axi_awready = !aw_ff;
    assign s_axi_wready = !w_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign card_clock = clk_ff;
    assign card_reset = rst_ff;
    assign card_supply_sel = sup_ff;
    assign card_contacts_active = act_ff;
    assign osc_high_freq = osc_ff;
    assign deep_power_save = deep_ff;
    assign status_interrupt_out = 1'b0;
    assign status_interrupt_oe_n = int_n_ff; // R8
    assign irq = irq_ff;

    contacts_idle_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
        !supply_ok |=> ##1 !act_ff) else $error("contacts live without supply");
    reset_follows_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        card_reset |-> $past(act_ff)) else $error("card reset outside session");
    osc_low_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        $past(sess_n) |-> !osc_high_freq) else $error("oscillator high while idle");
    int_drop_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        !supply_ok && state_ff != CCP_ST_DEEP |=> !int_n_ff) else $error("int not low");
    sup_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        state_ff == CCP_ST_ACTIVE && $past(state_ff) == CCP_ST_ACTIVE |-> $stable(sup_ff))
        else $error("supply changed in session");
    sup_pick_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        act_req && state_ff == CCP_ST_SHUTDOWN && !sel_lv_n |=> sup_ff == CCP_SUP_1V8)
        else $error("1.8 V not chosen");
    sup_hv_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        act_req && state_ff == CCP_ST_SHUTDOWN && sel_lv_n |=>
        sup_ff == (($past(sel_hv)) ? CCP_SUP_5V0 : CCP_SUP_3V0)) else $error("bad 5/3 V");
    deb_wait_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        $changed(pres_db_ff) |-> $past(db_done)) else $error("presence not debounced");
    act_start_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        act_req && state_ff == CCP_ST_SHUTDOWN |=> state_ff == CCP_ST_ACTIVE)
        else $error("activation not started");
    deep_enter_a: assert property (@(posedge aclk) disable iff (!aresetn) // R13
        state_ff == CCP_ST_SHUTDOWN && deep_cond && !act_req |=> state_ff == CCP_ST_DEEP)
        else $error("deep mode missed");
    div_full_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        act_ff && cki_edge && {div_sel_a, div_sel_b} == 2'b10 |=> clk_ff != $past(clk_ff))
        else $error("full rate clock missed");
endmodule

// [dv/ccp_card_side.sv]
`timescale 1ns/1ps
module ccp_card_side (
    output logic card_present_n,
    output logic card_clock_in
);
    // External card clock runs free, 200 ns period, toggling on aclk falling edges, never on a rising one
    initial begin
        card_clock_in = 1'b0;
        forever #100 card_clock_in = ~card_clock_in;
    end
    initial card_present_n = 1'b1;
    // Contact chatter, each bounce far shorter than the debounce window
    task automatic insert;
        #3;
        repeat (3) begin
            #125 card_present_n = 1'b0;
            #75 card_present_n = 1'b1;
        end
        card_present_n = 1'b0;
    endtask
    task automatic remove;
        #3 card_present_n = 1'b1;
    endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import ccp_pkg::*;
    localparam int DEB = 16;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd, v;
    logic [3:0] wstrb;
    logic [1:0] rsp, es;
    logic lv, hv, rs, a, b;
    wire awready, wready, bvalid, arready, rvalid, pres_n, clk_in, cclk, crst, act, osc, deep;
    wire int_out, int_oe_n, irq;
    wire [1:0] bresp, rresp, sup;
    wire [31:0] rdata;
    // Open-drain pin with its pull-up
    wire int_pin = int_oe_n ? 1'b1 : int_out;
    int err_count, check_count, seed, i;

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    ccp_ctrl #(.DEBOUNCE_CYC(DEB)) ccp_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .card_present_n(pres_n), .card_clock_in(clk_in), .card_clock(cclk), .card_reset(crst),
        .card_supply_sel(sup), .card_contacts_active(act), .osc_high_freq(osc),
        .deep_power_save(deep), .status_interrupt_out(int_out),
        .status_interrupt_oe_n(int_oe_n), .irq(irq));
    ccp_card_side ccp_card_side_inst (.card_present_n(pres_n), .card_clock_in(clk_in));

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task timed_out(input string what);
        err_count++;
        $display("ERROR %0t: timeout waiting for %s", $time, what);
        tally_and_finish();
    endtask
    task axi_write(input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 100) timed_out("write response");
        rsp = bresp;
        bready <= 1'b0;
    endtask
    task axi_read(input logic [7:0] ad);
        int n;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 100) timed_out("read data");
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    function logic sig(input int k);
        case (k)
            0: return act;
            1: return deep;
            default: return int_pin;
        endcase
    endfunction
    task wait_level(input int k, input logic lvl, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge aclk);
            if (sig(k) === lvl) return;
        end
        timed_out("output level");
    endtask
    function logic [31:0] mk(logic l, logic h, logic r, logic s, logic da, logic db, logic ok);
        return {25'h0, ok, db, da, s, r, h, l};
    endfunction
    function logic [1:0] exp_supply(logic l, logic h);
        return !l ? CCP_SUP_1V8 : (h ? CCP_SUP_5V0 : CCP_SUP_3V0);
    endfunction
    function int exp_div(logic da, logic db);
        case ({da, db})
            2'b00: return 8;
            2'b01: return 4;
            2'b11: return 2;
            default: return 1;
        endcase
    endfunction
    // Ratio check tolerates one partial period at each end of the window
    task measure_div(input int div);
        int n, ins, outs;
        logic pi, po;
        repeat (128) @(posedge aclk);
        ins = 0;
        outs = 0;
        pi = clk_in;
        po = cclk;
        for (n = 0; n < 512; n++) begin
            @(posedge aclk);
            ins += int'(clk_in && !pi);
            outs += int'(cclk && !po);
            pi = clk_in;
            po = cclk;
        end
        check(32'(outs * div >= ins - div && outs * div <= ins + div), 1, "clock ratio");
    endtask

    initial begin
        seed = 32'h481a;
        err_count = 0;
        check_count = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        check(int_pin, 0, "interrupt at power-up");
        check(act, 0, "contacts at power-up");
        check(osc, 0, "oscillator idle");
        axi_read(CCP_CTRL_OFS);
        check(rd, CCP_CTRL_RESET, "ctrl reset value");
        axi_read(8'h10);
        check(rd, 32'h0, "unmapped read data");
        check(rsp, CCP_BRESP_DECERR, "unmapped read response");
        axi_write(8'h20, 32'hffff_ffff);
        check(rsp, CCP_BRESP_DECERR, "unmapped write");
        axi_read(CCP_CTRL_OFS);
        check(rd, CCP_CTRL_RESET, "ctrl after unmapped write");
        axi_write(CCP_IRQ_MASK_OFS, 32'h7);
        ccp_card_side_inst.insert();
        axi_read(CCP_STAT_OFS);
        check(rd[1], 0, "presence before debounce");
        repeat (DEB + 10) @(posedge aclk);
        axi_read(CCP_STAT_OFS);
        check(rd[1], 1, "presence after debounce");
        check(int_pin, 0, "interrupt while unpowered");
        check(irq, 1, "presence event irq");
        axi_write(CCP_IRQ_STAT_OFS, 32'h1);
        axi_read(CCP_IRQ_STAT_OFS);
        check(rd[0], 0, "presence event cleared");
        check(irq, 0, "irq after clear");
        axi_write(CCP_CTRL_OFS, mk(1, 1, 0, 1, 0, 0, 1));
        wait_level(2, 1'b1, 20);
        for (i = 0; i < 8; i++) begin
            v = (i < 4) ? {27'h0, 2'(i), 1'(i), i[1] == 0, (i == 1 || i == 2)} : $random(seed);
            {b, a, rs, hv, lv} = v[4:0];
            es = exp_supply(lv, hv);
            axi_write(CCP_CTRL_OFS, mk(lv, hv, rs, 0, a, b, 1));
            wait_level(0, 1'b1, 2000);
            // Card reset trails the contacts by one register stage
            @(posedge aclk);
            check(sup, es, "supply choice");
            check(osc, 1, "oscillator in session");
            check(crst, rs, "card reset follows request");
            axi_write(CCP_CTRL_OFS, mk(!lv, !hv, !rs, 0, a, b, 1));
            repeat (4) @(posedge aclk);
            check(sup, es, "supply held in session");
            check(crst, !rs, "card reset follows change");
            measure_div(exp_div(a, b));
            axi_write(CCP_CTRL_OFS, mk(lv, hv, 0, 1, a, b, 1));
            wait_level(0, 1'b0, 2000);
            repeat (2) @(posedge aclk);
            check(osc, 0, "oscillator after session");
            check({cclk, crst}, 0, "contacts idle");
        end
        axi_write(CCP_CTRL_OFS, mk(1, 1, 0, 0, 0, 0, 1));
        wait_level(0, 1'b1, 2000);
        axi_write(CCP_CTRL_OFS, mk(1, 1, 0, 0, 0, 0, 0));
        wait_level(2, 1'b0, 4);
        wait_level(0, 1'b0, 2000);
        axi_read(CCP_IRQ_STAT_OFS);
        check(rd[CCP_IRQ_SUPPLY_FAIL], 1, "supply fail event");
        axi_write(CCP_CTRL_OFS, mk(0, 0, 0, 1, 0, 0, 1));
        wait_level(1, 1'b1, 10);
        axi_write(CCP_CTRL_OFS, mk(0, 1, 0, 1, 0, 0, 1));
        wait_level(1, 1'b0, 10);
        ccp_card_side_inst.remove();
        repeat (DEB + 10) @(posedge aclk);
        check(int_pin, 0, "interrupt without card");
        tally_and_finish();
    end
endmodule
